// File: bslc_pkg.sv
/*
  bslc_pkg: shared constants and types for the bit-skip / logic / call
  execution block: register map, field layout, opcodes, reset values.
  Assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address.
*/
// Behaviour
// - skip-if-clear: bit 0 discards next, two cycles
// - skip-if-set: bit 1 discards next, two cycles
// - file address 0..127, bit index 0..7
// - and: acc and register, null flag only
// - selector 0 to accumulator, 1 to register
// - complement register, route result, update null flag
// - watchdog clear zeroes counter and prescaler
// - watchdog clear sets expired and sleep flags
// - call pushes program counter plus one
// - call loads 11-bit target into pc low
// - call loads pc high from page latch
// - call always takes two cycles
// - clear writes 00h, sets null flag
`default_nettype none
package bslc_pkg;

  // register byte offsets
  localparam logic [11:0] BSLC_OFF_INSTR  = 12'h000;
  localparam logic [11:0] BSLC_OFF_ACC    = 12'h004;
  localparam logic [11:0] BSLC_OFF_PC     = 12'h008;
  localparam logic [11:0] BSLC_OFF_PAGE   = 12'h00c;
  localparam logic [11:0] BSLC_OFF_STATUS = 12'h010;
  localparam logic [11:0] BSLC_OFF_WDOG   = 12'h014;
  localparam logic [11:0] BSLC_OFF_STACK  = 12'h018;
  localparam logic [2:0]  BSLC_FILE_BASE  = 3'h1;   // addr[11:9] of file window 0x200..0x3fc

  // register select codes
  localparam logic [3:0] BSLC_SEL_NONE   = 4'h0;
  localparam logic [3:0] BSLC_SEL_INSTR  = 4'h1;
  localparam logic [3:0] BSLC_SEL_ACC    = 4'h2;
  localparam logic [3:0] BSLC_SEL_PC     = 4'h3;
  localparam logic [3:0] BSLC_SEL_PAGE   = 4'h4;
  localparam logic [3:0] BSLC_SEL_STATUS = 4'h5;
  localparam logic [3:0] BSLC_SEL_WDOG   = 4'h6;
  localparam logic [3:0] BSLC_SEL_STACK  = 4'h7;
  localparam logic [3:0] BSLC_SEL_FILE   = 4'h8;

  // status register bit positions
  localparam int BSLC_ST_BUSY  = 0;
  localparam int BSLC_ST_NULL  = 2;
  localparam int BSLC_ST_SLEEP = 3;
  localparam int BSLC_ST_WDEXP = 4;
  localparam int BSLC_ST_CYC0  = 8;
  localparam int BSLC_ST_SKIP  = 10;
  localparam int BSLC_STK_PTR0 = 16;

  // opcodes in the instruction word
  localparam logic [3:0] BSLC_OP_NOP      = 4'h0;
  localparam logic [3:0] BSLC_OP_SKIP_CLR = 4'h1;
  localparam logic [3:0] BSLC_OP_SKIP_SET = 4'h2;
  localparam logic [3:0] BSLC_OP_AND      = 4'h3;
  localparam logic [3:0] BSLC_OP_COMP     = 4'h4;
  localparam logic [3:0] BSLC_OP_CLEAR    = 4'h5;
  localparam logic [3:0] BSLC_OP_CLR_WDOG = 4'h6;
  localparam logic [3:0] BSLC_OP_CALL     = 4'h7;

  // sizes and reset values
  localparam int          BSLC_FILE_DEPTH = 128;
  localparam int          BSLC_STACK_DEPTH = 8;
  localparam logic [7:0]  BSLC_ACC_RST    = 8'h00;
  localparam logic [12:0] BSLC_PC_RST     = 13'h0000;
  localparam logic [7:0]  BSLC_WDOG_RST   = 8'h00;
  localparam logic [1:0]  BSLC_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  BSLC_RESP_SLVERR = 2'h2;

  // instruction word layout, low 26 bits of the instruction register
  typedef struct packed {
    logic [10:0] k;    // call target
    logic        d;    // destination selector
    logic [2:0]  b;    // bit index
    logic [6:0]  f;    // file address
    logic [3:0]  op;
  } bslc_instr_t;

  // status flags
  typedef struct packed {
    logic watchdog_expired_flag;
    logic sleep_entered_flag;
    logic null_flag;
  } bslc_flags_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_SECOND} bslc_state_t;

endpackage : bslc_pkg
`default_nettype wire

// File: bslc_mem.sv
/*
  bslc_mem: simple dual-port memory, one write port and one read port,
  read data registered. Assumes a single clock and no reset on contents.
*/
`timescale 1ns/100ps
`default_nettype none
module bslc_mem #(
  parameter int W  = 8,
  parameter int D  = 128,
  parameter int AW = 7
) (
  input  wire logic          aclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic [W-1:0]  rdata
);

  logic [W-1:0] mem [D];

  // write then registered read (read sees the old word on a collision)
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : bslc_mem
`default_nettype wire

// File: bslc_exec.sv
/*
  bslc_exec: executes bit-test-skip, and, complement, clear, watchdog
  clear and call instructions written to the instruction register.
  Assumes an AXI4-Lite master on aclk and one instruction at a time.
*/
`timescale 1ns/100ps
`default_nettype none
module bslc_exec
  import bslc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // address decode, shared by the write and read paths
  function automatic logic [3:0] reg_sel(input logic [11:0] a);
    logic [11:0] w;
    w = {a[11:2], 2'b00};
    if (a[11:9] == BSLC_FILE_BASE) return BSLC_SEL_FILE;
    case (w)
      BSLC_OFF_INSTR:  return BSLC_SEL_INSTR;
      BSLC_OFF_ACC:    return BSLC_SEL_ACC;
      BSLC_OFF_PC:     return BSLC_SEL_PC;
      BSLC_OFF_PAGE:   return BSLC_SEL_PAGE;
      BSLC_OFF_STATUS: return BSLC_SEL_STATUS;
      BSLC_OFF_WDOG:   return BSLC_SEL_WDOG;
      BSLC_OFF_STACK:  return BSLC_SEL_STACK;
      default:         return BSLC_SEL_NONE;
    endcase
  endfunction : reg_sel

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : merge

  bslc_state_t st;
  bslc_state_t next_st;
  bslc_instr_t cur;
  bslc_flags_t flg;
  bslc_flags_t next_flg;
  logic [7:0]  acc;
  logic [7:0]  next_acc;
  logic [12:0] pc;
  logic [12:0] next_pc;
  logic [7:0]  page_latch;
  logic [7:0]  wdog_cnt;
  logic [7:0]  wdog_pre;
  logic [2:0]  sp;
  logic [1:0]  last_cycles;
  logic [1:0]  next_cycles;
  logic        skipped;
  logic        next_skipped;
  logic        ar_pend;
  logic [3:0]  rsel_q;
  logic        mem_we;
  logic        stk_we;
  logic        wdog_clr;
  logic [7:0]  mem_rdata;
  logic [12:0] stk_rdata;
  logic [31:0] rd_word;

  // write and read handshakes, register selects
  wire         wr_fire  = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
  wire         ar_fire  = s_axi_arready & s_axi_arvalid;
  wire  [3:0]  wsel     = reg_sel(s_axi_awaddr);
  wire  [3:0]  rsel     = reg_sel(s_axi_araddr);
  wire         exec     = (st == ST_EXEC);
  wire  [31:0] old_word = (wsel == BSLC_SEL_INSTR) ? {6'h00, cur} :
                          (wsel == BSLC_SEL_PC)    ? {19'h00000, pc} :
                          (wsel == BSLC_SEL_PAGE)  ? {24'h000000, page_latch} :
                          (wsel == BSLC_SEL_STATUS) ?
                            {27'h0000000, flg.watchdog_expired_flag, flg.sleep_entered_flag,
                             flg.null_flag, 2'b00} :
                          {24'h000000, acc};
  wire  [31:0] wv       = merge(old_word, s_axi_wdata, s_axi_wstrb);

  // operand decode and results
  wire         bit_val  = mem_rdata[cur.b];
  wire         skip_hit = (cur.op == BSLC_OP_SKIP_CLR) ? ~bit_val :
                          (cur.op == BSLC_OP_SKIP_SET) ?  bit_val :
                          1'b0;
  wire  [7:0]  res      = (cur.op == BSLC_OP_AND)  ? (acc & mem_rdata) :
                          (cur.op == BSLC_OP_COMP) ? ~mem_rdata :
                          8'h00;
  wire         res_null = (res == 8'h00);
  wire  [12:0] pc_inc   = pc + 13'h0001;
  wire  [12:0] pc_skip  = pc + 13'h0002;
  wire         wdog_tick = (wdog_pre == 8'hff);
  wire         wdog_wrap = wdog_tick & (wdog_cnt == 8'hff) & ~wdog_clr;

  // memory port selection: execution owns the read port outside idle and the write port in ST_EXEC only
  wire  [6:0]  mem_waddr = exec ? cur.f : s_axi_awaddr[8:2];
  wire  [7:0]  mem_wdata = exec ? res : s_axi_wdata[7:0];
  wire  [6:0]  mem_raddr = (st == ST_IDLE) ? s_axi_araddr[8:2] : cur.f;
  wire  [2:0]  stk_raddr = sp - 3'h1;

  bslc_mem #(.W(8), .D(BSLC_FILE_DEPTH), .AW(7)) u_file (
    .aclk  (aclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  bslc_mem #(.W(13), .D(BSLC_STACK_DEPTH), .AW(3)) u_stack (
    .aclk  (aclk),
    .we    (stk_we),
    .waddr (sp),
    .wdata (pc_inc),
    .raddr (stk_raddr),
    .rdata (stk_rdata)
  );

  // next-state and register update selection
  always_comb begin
    next_st      = st;
    next_acc     = acc;
    next_pc      = pc;
    next_flg     = flg;
    next_cycles  = last_cycles;
    next_skipped = skipped;
    mem_we       = 1'b0;
    stk_we       = 1'b0;
    wdog_clr     = 1'b0;
    case (st)
      ST_IDLE: begin
        if (wr_fire) begin
          case (wsel)
            BSLC_SEL_INSTR:  next_st = ST_FETCH;
            BSLC_SEL_ACC:    next_acc = wv[7:0];
            BSLC_SEL_PC:     next_pc = wv[12:0];
            BSLC_SEL_STATUS: next_flg = {wv[BSLC_ST_WDEXP], wv[BSLC_ST_SLEEP], wv[BSLC_ST_NULL]};
            BSLC_SEL_FILE:   mem_we = s_axi_wstrb[0];
            default: ;
          endcase
        end
      end
      ST_FETCH: next_st = ST_EXEC;
      ST_EXEC: begin
        next_st      = ST_IDLE;
        next_pc      = pc_inc;
        next_cycles  = 2'h1;
        next_skipped = 1'b0;
        case (cur.op)
          BSLC_OP_SKIP_CLR, BSLC_OP_SKIP_SET: begin
            if (skip_hit) begin                     // flags untouched
              next_pc      = pc_skip;
              next_st      = ST_SECOND;
              next_cycles  = 2'h2;
              next_skipped = 1'b1;
            end
          end
          BSLC_OP_AND, BSLC_OP_COMP: begin
            next_flg.null_flag = res_null;
            if (cur.d) begin
              mem_we = 1'b1;
            end else begin
              next_acc = res;
            end
          end
          BSLC_OP_CLEAR: begin
            mem_we             = 1'b1;
            next_flg.null_flag = 1'b1;
          end
          BSLC_OP_CLR_WDOG: begin
            wdog_clr                       = 1'b1;
            next_flg.watchdog_expired_flag = 1'b1;
            next_flg.sleep_entered_flag    = 1'b1;
          end
          BSLC_OP_CALL: begin
            stk_we      = 1'b1;
            next_pc     = {page_latch[4:3], cur.k};
            next_st     = ST_SECOND;
            next_cycles = 2'h2;
          end
          default: ;
        endcase
      end
      ST_SECOND: next_st = ST_IDLE;
      default:   next_st = ST_IDLE;
    endcase
    if (wdog_wrap) begin
      next_flg.watchdog_expired_flag = 1'b0;       // counter ran out
    end
  end

  // core state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st          <= ST_IDLE;
      acc         <= BSLC_ACC_RST;
      pc          <= BSLC_PC_RST;
      flg         <= '1;
      last_cycles <= 2'h0;
      skipped     <= 1'b0;
      sp          <= 3'h0;
    end else begin
      st          <= next_st;
      acc         <= next_acc;
      pc          <= next_pc;
      flg         <= next_flg;
      last_cycles <= next_cycles;
      skipped     <= next_skipped;
      sp          <= stk_we ? sp + 3'h1 : sp;      // circular return stack
    end
  end

  // instruction and page latch registers, written only from the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur        <= '0;
      page_latch <= 8'h00;
    end else if (wr_fire && st == ST_IDLE) begin
      if (wsel == BSLC_SEL_INSTR) cur <= bslc_instr_t'(wv[25:0]);
      if (wsel == BSLC_SEL_PAGE) page_latch <= wv[7:0];
    end
  end

  // watchdog prescaler and counter
  always_ff @(posedge aclk) begin
    if (!aresetn || wdog_clr) begin
      wdog_pre <= BSLC_WDOG_RST;
      wdog_cnt <= BSLC_WDOG_RST;
    end else begin
      wdog_pre <= wdog_pre + 8'h01;
      wdog_cnt <= wdog_tick ? wdog_cnt + 8'h01 : wdog_cnt;
    end
  end

  // write channel: address and data taken together, one at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= BSLC_RESP_OKAY;
    end else begin
      s_axi_awready <= ~s_axi_awready & ~s_axi_bvalid & s_axi_awvalid & s_axi_wvalid &
                       (st == ST_IDLE) & ~s_axi_arready;
      s_axi_wready  <= ~s_axi_awready & ~s_axi_bvalid & s_axi_awvalid & s_axi_wvalid &
                       (st == ST_IDLE) & ~s_axi_arready;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == BSLC_SEL_NONE) ? BSLC_RESP_SLVERR : BSLC_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data selection
  always_comb begin
    case (rsel_q)
      BSLC_SEL_INSTR:  rd_word = {6'h00, cur};
      BSLC_SEL_ACC:    rd_word = {24'h000000, acc};
      BSLC_SEL_PC:     rd_word = {19'h00000, pc};
      BSLC_SEL_PAGE:   rd_word = {24'h000000, page_latch};
      BSLC_SEL_STATUS: rd_word = {21'h000000, skipped, last_cycles, 3'h0,
                                  flg.watchdog_expired_flag, flg.sleep_entered_flag,
                                  flg.null_flag, 1'b0, (st != ST_IDLE)};
      BSLC_SEL_WDOG:   rd_word = {16'h0000, wdog_pre, wdog_cnt};
      BSLC_SEL_STACK:  rd_word = {13'h0000, sp, 3'h0, stk_rdata};
      BSLC_SEL_FILE:   rd_word = {24'h000000, mem_rdata};
      default:         rd_word = 32'h00000000;
    endcase
  end

  // read channel: memory read one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= BSLC_RESP_OKAY;
      ar_pend       <= 1'b0;
      rsel_q        <= BSLC_SEL_NONE;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~ar_pend & ~s_axi_rvalid & s_axi_arvalid &
                       (st == ST_IDLE) & ~s_axi_awready;
      ar_pend       <= ar_fire;
      if (ar_fire) rsel_q <= rsel;
      if (ar_pend) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= (rsel_q == BSLC_SEL_NONE) ? BSLC_RESP_SLVERR : BSLC_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_second_then_idle;
    (st == ST_SECOND) ##1 (st == ST_IDLE);
  endsequence

  a_skip_clear_pc: assert property (
    exec && cur.op == BSLC_OP_SKIP_CLR && !bit_val |=>
      pc == $past(pc) + 13'h0002 && $stable(flg) ##0 s_second_then_idle)
    else $error("skip-if-clear did not skip over the next word");
  a_skip_set_pc: assert property (
    exec && cur.op == BSLC_OP_SKIP_SET |=>
      (pc == $past(pc) + ($past(bit_val) ? 13'h0002 : 13'h0001)) && $stable(flg))
    else $error("skip-if-set advanced the counter wrongly");
  a_and_to_acc: assert property (
    exec && cur.op == BSLC_OP_AND && !cur.d |=>
      acc == ($past(acc) & $past(mem_rdata)) && $stable(flg.sleep_entered_flag))
    else $error("and result not in accumulator");
  a_dest_reg: assert property (
    exec && (cur.op == BSLC_OP_AND || cur.op == BSLC_OP_COMP) && cur.d |->
      mem_we && mem_waddr == cur.f ##1 $stable(acc))
    else $error("selector 1 did not write the register");
  a_comp_to_acc: assert property (
    exec && cur.op == BSLC_OP_COMP && !cur.d |=> acc == ~$past(mem_rdata))
    else $error("complement result wrong");
  a_wdog_zero: assert property (
    exec && cur.op == BSLC_OP_CLR_WDOG |=> wdog_cnt == 8'h00 && wdog_pre == 8'h00)
    else $error("watchdog not cleared");
  a_wdog_flags: assert property (
    exec && cur.op == BSLC_OP_CLR_WDOG |=>
      flg.watchdog_expired_flag && flg.sleep_entered_flag)
    else $error("watchdog clear did not set both flags");
  a_call_push: assert property (
    exec && cur.op == BSLC_OP_CALL |-> stk_we ##1 sp == $past(sp) + 3'h1)
    else $error("call did not push");
  a_call_target: assert property (
    exec && cur.op == BSLC_OP_CALL |=>
      pc == {$past(page_latch[4:3]), $past(cur.k)})
    else $error("call target wrong");
  a_call_two: assert property (
    exec && cur.op == BSLC_OP_CALL |=> s_second_then_idle)
    else $error("call did not take two cycles");
  a_clear_reg: assert property (
    exec && cur.op == BSLC_OP_CLEAR |-> mem_we && mem_wdata == 8'h00 ##1 flg.null_flag)
    else $error("clear did not write zero and set null flag");
  a_null_flag: assert property (
    exec && (cur.op == BSLC_OP_AND || cur.op == BSLC_OP_COMP) |=>
      flg.null_flag == ($past(res) == 8'h00))
    else $error("null flag mismatch");

endmodule : bslc_exec
`default_nettype wire

// File: bit_skip_logic_call_exec_tb.sv
/*
  bit_skip_logic_call_exec_tb: self-checking bench for bslc_exec; runs
  instructions and reads results back over AXI4-Lite.
  Assumes the register map of bslc_pkg and the bus timing of bslc_exec.
*/
`timescale 1ns/100ps
`default_nettype none
module bit_skip_logic_call_exec_tb import bslc_pkg::*;
  ;
  localparam logic [7:0] PAT = 8'h5a;  // bit pattern for the skip tests

  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [11:0] s_axi_awaddr  = 12'h000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'hf;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready  = 1'b0;
  logic [11:0] s_axi_araddr  = 12'h000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready  = 1'b0;
  int          err_count     = 0;
  int          comparisons   = 0;
  int          cyc           = 0;

  bslc_exec dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  // cut a hang short well beyond the expected run length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // instruction word and file window address
  function automatic logic [31:0] mk(input logic [3:0] op, input logic [6:0] f,
                                     input logic [2:0] b, input logic d, input logic [10:0] k);
    return {6'h00, k, d, b, f, op};  // same field order as bslc_instr_t
  endfunction : mk

  function automatic logic [11:0] fa(input logic [6:0] f);
    return 12'h200 + {3'h0, f, 2'b00};
  endfunction : fa

  // write: address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end while (!(aw_done && w_done && s_axi_bvalid === 1'b1));
    check({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
    logic ar_done;
    ar_done = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ar_done && s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
        ar_done = 1'b1;
      end
    end while (!(ar_done && s_axi_rvalid === 1'b1));
    d = s_axi_rdata;
    check({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
    s_axi_rready <= 1'b0;
  endtask : rd

  // start an instruction, then read status once the core is idle again
  task automatic exec(input logic [31:0] ins, output logic [31:0] st);
    wr(BSLC_OFF_INSTR, ins, BSLC_RESP_OKAY);
    rd(BSLC_OFF_STATUS, st, BSLC_RESP_OKAY);
  endtask : exec

  // reset values, unmapped address refused
  task automatic t_reset_bus;
    logic [31:0] v;
    rd(BSLC_OFF_STATUS, v, BSLC_RESP_OKAY);
    check({27'h0, v[4:0]}, 32'h1c, "status after reset");
    rd(BSLC_OFF_PC, v, BSLC_RESP_OKAY);
    check({19'h0, v[12:0]}, 32'h0, "pc after reset");
    wr(12'h100, 32'hffff_ffff, BSLC_RESP_SLVERR);
    rd(12'h100, v, BSLC_RESP_SLVERR);
    check(v, 32'h0, "unmapped read data");
  endtask : t_reset_bus

  // both skip polarities over every bit index at the top file address
  task automatic t_skip;
    logic [31:0] st;
    logic [31:0] v;
    logic        taken;
    wr(fa(7'h7f), {24'h0, PAT}, BSLC_RESP_OKAY);
    wr(BSLC_OFF_STATUS, 32'h14, BSLC_RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      taken = (i < 8) ? ~PAT[i % 8] : PAT[i % 8];
      wr(BSLC_OFF_PC, 32'h10, BSLC_RESP_OKAY);
      exec(mk((i < 8) ? BSLC_OP_SKIP_CLR : BSLC_OP_SKIP_SET, 7'h7f, 3'(i), 1'b0, 11'h0), st);
      rd(BSLC_OFF_PC, v, BSLC_RESP_OKAY);
      check({19'h0, v[12:0]}, taken ? 32'h12 : 32'h11, "skip pc");
      check({30'h0, st[9:8]}, taken ? 32'h2 : 32'h1, "skip cycles");
      check({31'h0, st[BSLC_ST_SKIP]}, {31'h0, taken}, "skip marker");
      check({29'h0, st[4:2]}, 32'h5, "skip flags kept");
    end
  endtask : t_skip

  // byte operation with preset accumulator and register; null flag preset opposite
  task automatic byte_op(input logic [3:0] op, input logic [6:0] f, input logic d,
                         input logic [7:0] a0, input logic [7:0] r0,
                         input logic [7:0] ea, input logic [7:0] er, input logic en);
    logic [31:0] st;
    logic [31:0] v;
    wr(BSLC_OFF_STATUS, {27'h0, 2'b11, ~en, 2'b00}, BSLC_RESP_OKAY);
    wr(BSLC_OFF_ACC, {24'h0, a0}, BSLC_RESP_OKAY);
    wr(fa(f), {24'h0, r0}, BSLC_RESP_OKAY);
    exec(mk(op, f, 3'h0, d, 11'h0), st);
    rd(BSLC_OFF_ACC, v, BSLC_RESP_OKAY);
    check({24'h0, v[7:0]}, {24'h0, ea}, "accumulator");
    rd(fa(f), v, BSLC_RESP_OKAY);
    check({24'h0, v[7:0]}, {24'h0, er}, "file register");
    check({29'h0, st[4:2]}, {29'h0, 2'b11, en}, "flags");
  endtask : byte_op

  // watchdog clear zeroes the running count and sets both flags
  task automatic t_wdog;
    logic [31:0] st;
    logic [31:0] v;
    wr(BSLC_OFF_STATUS, 32'h0, BSLC_RESP_OKAY);
    repeat (600) @(posedge aclk);
    rd(BSLC_OFF_WDOG, v, BSLC_RESP_OKAY);
    check({31'h0, v[7:0] != 8'h00}, 32'h1, "watchdog running");
    exec(mk(BSLC_OP_CLR_WDOG, 7'h0, 3'h0, 1'b0, 11'h0), st);
    rd(BSLC_OFF_WDOG, v, BSLC_RESP_OKAY);
    check({24'h0, v[7:0]}, 32'h0, "watchdog counter");
    check({31'h0, v[15:8] < 8'h20}, 32'h1, "watchdog prescaler");
    check({29'h0, st[4:2]}, 32'h6, "watchdog flags");
  endtask : t_wdog

  // two calls in a row: target, page bits, pushed return address
  task automatic t_call;
    logic [7:0]  pg [2]   = '{8'h18, 8'he8};
    logic [10:0] kk [2]   = '{11'h5a5, 11'h7ff};
    logic [12:0] epc [2]  = '{13'h1da5, 13'h0fff};
    logic [12:0] etop [2] = '{13'h0124, 13'h1da6};
    logic [31:0] st;
    logic [31:0] v;
    logic [2:0]  p0;
    rd(BSLC_OFF_STACK, v, BSLC_RESP_OKAY);
    p0 = v[18:16];
    wr(BSLC_OFF_PC, 32'h123, BSLC_RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      wr(BSLC_OFF_PAGE, {24'h0, pg[i]}, BSLC_RESP_OKAY);
      exec(mk(BSLC_OP_CALL, 7'h0, 3'h0, 1'b0, kk[i]), st);
      check({30'h0, st[9:8]}, 32'h2, "call cycles");
      rd(BSLC_OFF_PC, v, BSLC_RESP_OKAY);
      check({19'h0, v[12:0]}, {19'h0, epc[i]}, "call pc");
      rd(BSLC_OFF_STACK, v, BSLC_RESP_OKAY);
      check({19'h0, v[12:0]}, {19'h0, etop[i]}, "return address");
      check({29'h0, v[18:16]}, {29'h0, 3'(p0 + 3'(i + 1))}, "stack depth");
    end
  endtask : t_call

  // main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_bus();
    t_skip();
    byte_op(BSLC_OP_AND, 7'h7f, 1'b0, 8'hf0, 8'h3c, 8'h30, 8'h3c, 1'b0);
    byte_op(BSLC_OP_AND, 7'h7f, 1'b1, 8'h0f, 8'hf0, 8'h0f, 8'h00, 1'b1);
    byte_op(BSLC_OP_COMP, 7'h00, 1'b0, 8'h33, 8'hff, 8'h00, 8'hff, 1'b1);
    byte_op(BSLC_OP_COMP, 7'h00, 1'b1, 8'h33, 8'h5a, 8'h33, 8'ha5, 1'b0);
    byte_op(BSLC_OP_CLEAR, 7'h09, 1'b0, 8'h33, 8'h77, 8'h33, 8'h00, 1'b1);
    t_wdog();
    t_call();
    finish_test();
  end
endmodule : bit_skip_logic_call_exec_tb
`default_nettype wire
